// ### pkg/src_map.svh
/*
 holds: register offsets, field positions, reset values and timing counts
 for the system reset controller.
 assumes: included by its bare name from the design and the bench.
*/
`ifndef SRC_MAP_SVH
`define SRC_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SRC_OFS_CAUSE 8'h00
`define SRC_OFS_BOR_CTRL 8'h04
`define SRC_OFS_LDO_CTRL 8'h08
`define SRC_OFS_SYS_CTRL 8'h0C
`define SRC_OFS_PRST0 8'h10
`define SRC_OFS_PRST1 8'h14
`define SRC_OFS_PRST2 8'h18
`define SRC_OFS_WD_LOAD 8'h1C
`define SRC_OFS_WD_CTRL 8'h20
`define SRC_OFS_WD_STAT 8'h24
`define SRC_OFS_ID_FIRST 8'h40
`define SRC_OFS_ID_LAST 8'h58

// ----------------------------------------
// cause register fields
// ----------------------------------------
`define SRC_CAUSE_EXT 0
`define SRC_CAUSE_POR 1
`define SRC_CAUSE_BOR 2
`define SRC_CAUSE_WDT 3
`define SRC_CAUSE_SW 4

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define SRC_BOR_RST_EN_BIT 1
`define SRC_SYS_REQ_BIT 0
`define SRC_WD_EN_BIT 0
`define SRC_WD_RSTEN_BIT 1
`define SRC_LDO_RST 6'h00
`define SRC_WD_LOAD_RST 32'hFFFF_FFFF

// ----------------------------------------
// timing: hold after release, in cycles
// ----------------------------------------
`define SRC_HOLD_CYCLES 4

`endif

// ### pkg/src_pkg.sv
/*
 holds: types shared by the reset controller.
 assumes: nothing beyond the map header.
*/
package src_pkg;
    // sequencer states of the system reset
    typedef enum logic [1:0] {
        SRC_HELD,
        SRC_COUNT,
        SRC_RUN
    } src_state_t;
endpackage

// ### rtl/src_reset_ctrl.sv
/*
 holds: system reset controller: source merge, cause capture, brown-out
 control, peripheral soft resets, a watchdog and id registers over
 AXI4-Lite.
 assumes: i_rst_n is the power-on reset, asynchronous and active low;
 other inputs are synchronous to i_sys_clk except the pin, which is
 synchronised here.
*/
`timescale 1ns/100ps
`include "src_map.svh"

module src_reset_ctrl
    import src_pkg::*;
#(
    parameter int PERIPH_W = 32,
    parameter int DOMAINS = 2,
    parameter logic [31:0] ID_VAL0 = 32'h0000_0001 // arbitrary value
) (
    // clock and power-on reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // reset pin and supply monitor
    input wire logic i_ext_rst_n,
    input wire logic i_brownout,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // resets out, all active low
    output logic o_sys_rst_n,
    output logic o_tap_rst_n,
    output logic [PERIPH_W*DOMAINS-1:0] o_periph_rst_n,
    // events and regulator
    output logic o_bor_irq,
    output logic o_wdt_irq,
    output logic [5:0] o_regulator_voltage_adjust
);

    // ----------------------------------------
    // pin synchroniser and merge
    // ----------------------------------------
    logic pin_meta_reg; // first stage, read only by second
    logic pin_sync_reg; // synchronised pin, high = released
    logic brownout_reset_enable_reg;
    logic bor_irq_en_reg;
    logic sw_req_reg; // pending system request
    logic wdt_fire_reg; // watchdog second time-out
    logic ext_pend_reg, bor_pend_reg, wdt_pend_reg, sw_pend_reg;
    logic por_pend_reg; // set only by power-on, cleared once
    logic brownout_reset;
    logic ext_async_n;
    src_state_t state_reg;
    logic [2:0] hold_cnt_reg;
    logic sys_rst_n_reg;

    // a brown-out reset behaves as a pin assertion while enabled
    assign brownout_reset = i_brownout & brownout_reset_enable_reg;
    assign ext_async_n = i_rst_n & i_ext_rst_n;

    // pin asserts immediately, releases through two flops
    always_ff @(posedge i_sys_clk or negedge ext_async_n) begin
        if (!ext_async_n) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // release sequencer: hold, count a few cycles, run
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= SRC_HELD;
            hold_cnt_reg <= 3'h0;
            sys_rst_n_reg <= 1'b0;
        end else begin
            // any active source drops straight back to held
            if (!pin_sync_reg || brownout_reset || sw_req_reg
                    || wdt_fire_reg) begin
                state_reg <= SRC_HELD;
                hold_cnt_reg <= 3'h0;
                sys_rst_n_reg <= 1'b0;
            end else begin
                case (state_reg)
                    SRC_HELD: begin
                        state_reg <= SRC_COUNT;
                        hold_cnt_reg <= 3'h0;
                    end
                    SRC_COUNT: begin
                        if (hold_cnt_reg == 3'(`SRC_HOLD_CYCLES - 1)) begin
                            state_reg <= SRC_RUN;
                            sys_rst_n_reg <= 1'b1;
                        end else begin
                            hold_cnt_reg <= hold_cnt_reg + 3'h1;
                        end
                    end
                    SRC_RUN: sys_rst_n_reg <= 1'b1;
                    default: state_reg <= SRC_HELD;
                endcase
            end
        end
    end

    assign o_sys_rst_n = sys_rst_n_reg;

    // tap sees only power-on, never pin or other sources
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tap_rst_n <= 1'b0;
        end else begin
            o_tap_rst_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // cause capture
    // ----------------------------------------
    logic [4:0] reset_cause_reg;
    logic cause_wr;
    logic [31:0] wr_data;

    // pending flags remember which source held the reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            por_pend_reg <= 1'b1;
            ext_pend_reg <= 1'b0;
            bor_pend_reg <= 1'b0;
            wdt_pend_reg <= 1'b0;
            sw_pend_reg <= 1'b0;
        end else if (state_reg == SRC_RUN) begin
            por_pend_reg <= 1'b0;
            ext_pend_reg <= 1'b0;
            bor_pend_reg <= 1'b0;
            wdt_pend_reg <= 1'b0;
            sw_pend_reg <= 1'b0;
        end else begin
            ext_pend_reg <= ext_pend_reg | (!pin_sync_reg & !por_pend_reg);
            bor_pend_reg <= bor_pend_reg | brownout_reset;
            wdt_pend_reg <= wdt_pend_reg | wdt_fire_reg;
            sw_pend_reg <= sw_pend_reg | sw_req_reg;
        end
    end

    // sticky: latch on entry to run; set wins over a clear
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reset_cause_reg <= 5'h00;
        end else if (state_reg == SRC_COUNT && sys_rst_n_reg == 1'b0
                && hold_cnt_reg == 3'(`SRC_HOLD_CYCLES - 1)) begin
            if (por_pend_reg) begin
                reset_cause_reg <= 5'h00;
                reset_cause_reg[`SRC_CAUSE_POR] <= 1'b1;
            end else begin
                reset_cause_reg[`SRC_CAUSE_EXT] <=
                    reset_cause_reg[`SRC_CAUSE_EXT] | ext_pend_reg;
                reset_cause_reg[`SRC_CAUSE_BOR] <=
                    reset_cause_reg[`SRC_CAUSE_BOR] | bor_pend_reg;
                reset_cause_reg[`SRC_CAUSE_WDT] <=
                    reset_cause_reg[`SRC_CAUSE_WDT] | wdt_pend_reg;
                reset_cause_reg[`SRC_CAUSE_SW] <=
                    reset_cause_reg[`SRC_CAUSE_SW] | sw_pend_reg;
            end
        end else if (cause_wr) begin
            reset_cause_reg <= wr_data[4:0];
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic wr_fire;
    logic [7:0] wa;
    assign wa = aw_addr_reg;
    assign wr_data = w_data_reg;
    assign wr_fire = aw_got_reg & w_got_reg & !s_axi_bvalid;
    assign cause_wr = wr_fire && wa == `SRC_OFS_CAUSE;

    // accept address and data in either order, then respond
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_got_reg && !s_axi_awready
                && s_axi_awvalid;
            s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa <= `SRC_OFS_WD_STAT) ? 2'b00 : 2'b10;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [PERIPH_W-1:0] prst_reg [3];
    logic [31:0] watchdog_reload_value;
    logic wd_en_reg, wd_rsten_reg;
    logic wd_int_reg;
    logic wd_clr;
    assign wd_clr = wr_fire && wa == `SRC_OFS_WD_STAT;

    // brown-out, regulator, request and watchdog controls
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            brownout_reset_enable_reg <= 1'b0;
            bor_irq_en_reg <= 1'b0;
            o_regulator_voltage_adjust <= `SRC_LDO_RST;
            sw_req_reg <= 1'b0;
            watchdog_reload_value <= `SRC_WD_LOAD_RST;
            wd_en_reg <= 1'b0;
            wd_rsten_reg <= 1'b0;
        end else begin
            // request is a one-shot that clears once reset is held
            if (!sys_rst_n_reg) begin
                sw_req_reg <= 1'b0;
            end
            if (wr_fire) begin
                case (wa)
                    `SRC_OFS_BOR_CTRL: begin
                        brownout_reset_enable_reg <=
                            wr_data[`SRC_BOR_RST_EN_BIT];
                        bor_irq_en_reg <= wr_data[0];
                    end
                    `SRC_OFS_LDO_CTRL:
                        o_regulator_voltage_adjust <= wr_data[5:0];
                    `SRC_OFS_SYS_CTRL:
                        sw_req_reg <= wr_data[`SRC_SYS_REQ_BIT];
                    `SRC_OFS_WD_LOAD: watchdog_reload_value <= wr_data;
                    `SRC_OFS_WD_CTRL: begin
                        wd_en_reg <= wr_data[`SRC_WD_EN_BIT];
                        wd_rsten_reg <= wr_data[`SRC_WD_RSTEN_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // brown-out interrupt path when reset is not chosen
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bor_irq <= 1'b0;
        end else begin
            o_bor_irq <= i_brownout & bor_irq_en_reg
                & !brownout_reset_enable_reg;
        end
    end

    // ----------------------------------------
    // peripheral soft resets, one per unit
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_bank
            logic [PERIPH_W-1:0] arm_reg;
            // a set bit in PRST0 holds that unit in reset, clearing it releases; PRST1 and PRST2 bits only store; positions track gating
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    prst_reg[gi] <= '0;
                    arm_reg <= '0;
                end else if (!sys_rst_n_reg) begin
                    prst_reg[gi] <= '0;
                    arm_reg <= '0;
                end else begin
                    arm_reg <= prst_reg[gi];
                    if (wr_fire && wa == 8'(`SRC_OFS_PRST0 + 4 * gi)) begin
                        prst_reg[gi] <= wr_data[PERIPH_W-1:0];
                    end
                end
            end
        end
        for (gi = 0; gi < PERIPH_W * DOMAINS; gi++) begin : g_out
            // every domain of a unit follows that unit's bit in PRST0; PRST1 and PRST2 drive no output
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    o_periph_rst_n[gi] <= 1'b0;
                end else begin
                    o_periph_rst_n[gi] <= sys_rst_n_reg
                        & !(prst_reg[0][gi % PERIPH_W]);
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    logic [31:0] wd_cnt_reg;

    // first zero raises interrupt and reloads, second resets
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wd_cnt_reg <= `SRC_WD_LOAD_RST;
            wd_int_reg <= 1'b0;
            wdt_fire_reg <= 1'b0;
        end else if (!sys_rst_n_reg) begin
            wd_cnt_reg <= watchdog_reload_value;
            wd_int_reg <= 1'b0;
            wdt_fire_reg <= 1'b0;
        end else if (wd_en_reg && wd_cnt_reg == 32'h0000_0000) begin
            wd_cnt_reg <= watchdog_reload_value;
            if (wd_int_reg && wd_rsten_reg) begin
                wdt_fire_reg <= 1'b1;
            end
            wd_int_reg <= 1'b1;
        end else if (wr_fire && wa == `SRC_OFS_WD_LOAD) begin
            // a new load restarts the count at once; otherwise the
            // all-ones count left by power-on would take minutes
            wd_cnt_reg <= wr_data;
        end else if (wd_en_reg) begin
            wd_cnt_reg <= wd_cnt_reg - 32'h0000_0001;
            if (wd_clr) begin
                wd_int_reg <= 1'b0;
            end
        end
    end
    assign o_wdt_irq = wd_int_reg;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [31:0] rd_val;
    // seven identity words are constants; only the first is named
    always_comb begin
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `SRC_OFS_CAUSE: rd_val = {27'h0, reset_cause_reg};
            `SRC_OFS_BOR_CTRL: rd_val = {30'h0,
                brownout_reset_enable_reg, bor_irq_en_reg};
            `SRC_OFS_LDO_CTRL: rd_val = {26'h0, o_regulator_voltage_adjust};
            `SRC_OFS_PRST0: rd_val = 32'(prst_reg[0]);
            `SRC_OFS_PRST1: rd_val = 32'(prst_reg[1]);
            `SRC_OFS_PRST2: rd_val = 32'(prst_reg[2]);
            `SRC_OFS_WD_LOAD: rd_val = watchdog_reload_value;
            `SRC_OFS_WD_CTRL: rd_val = {30'h0, wd_rsten_reg, wd_en_reg};
            `SRC_OFS_WD_STAT: rd_val = {31'h0, wd_int_reg};
            `SRC_OFS_ID_FIRST: rd_val = ID_VAL0;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // single outstanding read, answered one cycle after acceptance
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= (s_axi_araddr <= `SRC_OFS_ID_LAST) ?
                    2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_BOR_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_reg == SRC_RUN && i_brownout && !brownout_reset_enable_reg
        && pin_sync_reg && !sw_req_reg && !wdt_fire_reg
        |=> state_reg == SRC_RUN)
        else $error("brown-out reset while disabled");
    AST_TAP_UP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_tap_rst_n)
        else $error("tap reset after power-on");
    AST_PIN_HOLD: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) !pin_sync_reg |=> !sys_rst_n_reg)
        else $error("reset released with pin low");
    AST_RELEASE: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $rose(sys_rst_n_reg) |->
        $past(state_reg == SRC_COUNT))
        else $error("release without count");
    AST_WD_RELOAD: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) sys_rst_n_reg && wd_en_reg
        && wd_cnt_reg == 0 ##1 sys_rst_n_reg |->
        wd_cnt_reg == $past(watchdog_reload_value))
        else $error("watchdog did not reload");
    AST_WD_FIRE: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) $rose(wdt_fire_reg) |->
        $past(wd_int_reg) && $past(wd_rsten_reg))
        else $error("watchdog reset without cause");
    AST_SW_REQ: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) sw_req_reg |=> !sys_rst_n_reg)
        else $error("request did not reset");
    AST_POR_ONLY: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) por_pend_reg && state_reg == SRC_RUN
        |-> reset_cause_reg == 5'h02)
        else $error("power-on cause not alone");

endmodule

// ### verification/src_supply_model.sv
/*
 holds: model of the reset pin network and the supply monitor.
 assumes: the bench commands pin hold and supply sag at clock edges.
*/
`timescale 1ns/100ps

// ----------------------------------------
// pin with pull-up, brown-out detector
// ----------------------------------------
module src_supply_model (
    // commands from the bench
    input wire logic i_pin_hold,
    input wire logic i_sag,
    // towards the block
    output logic o_ext_rst_n,
    output logic o_brownout
);
    // released pin floats to the pull-up level, never a stale value
    assign o_ext_rst_n = !i_pin_hold;
    // detector output is high while the supply sits below threshold
    assign o_brownout = i_sag;
endmodule

// ### verification/system_reset_control_tb.sv
/*
 holds: self-checking bench for the reset controller over AXI4-Lite.
 assumes: the block answers on its bus while the system reset is low.
*/
`timescale 1ns/100ps
`include "src_map.svh"

module system_reset_control_tb;
    import src_pkg::*;
    logic clk, rst_n, hold, sag, ext_n, bo;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sys_n, tap_n, bor_irq, wdt_irq;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic [63:0] prst_n;
    logic [5:0] regulator_voltage_adjust;
    int fail_count = 0;
    int compares = 0;

    // ----------------------------------------
    // clock, partner and device
    // ----------------------------------------
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    src_supply_model pm (.i_pin_hold(hold), .i_sag(sag),
        .o_ext_rst_n(ext_n), .o_brownout(bo));
    src_reset_ctrl uut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_ext_rst_n(ext_n), .i_brownout(bo),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .o_sys_rst_n(sys_n), .o_tap_rst_n(tap_n), .o_periph_rst_n(prst_n),
        .o_bor_irq(bor_irq), .o_wdt_irq(wdt_irq),
        .o_regulator_voltage_adjust(regulator_voltage_adjust));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("mismatches %0d of %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_up();
        fail_count++;
        $display("FAIL %0t wait ran out", $time);
        finish_test();
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) give_up();
        rsp = bresp;
        bready <= 0;
    endtask
    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) give_up();
        rd = rdata;
        rsp = rresp;
        rready <= 0;
    endtask
    // bounded wait for the system reset to reach a level
    task automatic wait_sys(input logic lvl);
        int n;
        for (n = 0; n < 300 && sys_n !== lvl; n++) @(posedge clk);
        if (n == 300) give_up();
    endtask
    task automatic por();
        rst_n <= 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        wait_sys(1);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int n;
        rst_n = 0;
        hold = 0;
        sag = 0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        por();
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0002);
        rdr(`SRC_OFS_BOR_CTRL);
        chk(rd, 32'h0000_0000);
        rdr(8'h40);
        chk(rd, 32'h0000_0001);
        rdr(8'h80);
        chk(rsp, 2'b10);
        wr(8'h40, 32'h0000_0000);
        chk(rsp, 2'b10);
        wr(`SRC_OFS_LDO_CTRL, 32'h0000_0015);
        chk(rsp, 2'b00);
        @(posedge clk);
        chk(regulator_voltage_adjust, 6'h15);
        // pin: core reset, tap untouched, synchroniser delay on release
        @(posedge clk) hold <= 1;
        repeat (4) @(posedge clk);
        chk({sys_n, tap_n, prst_n[0]}, 3'b010);
        hold <= 0;
        repeat (2) @(posedge clk);
        chk(sys_n, 1'b0);
        wait_sys(1);
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0003);
        // brown-out: interrupt only, then reset held while low
        wr(`SRC_OFS_BOR_CTRL, 32'h0000_0001);
        @(posedge clk) sag <= 1;
        repeat (10) @(posedge clk);
        chk({sys_n, bor_irq}, 2'b11);
        wr(`SRC_OFS_BOR_CTRL, 32'h0000_0002);
        wait_sys(0);
        repeat (20) @(posedge clk);
        chk(sys_n, 1'b0);
        sag <= 0;
        wait_sys(1);
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0007);
        // peripheral soft reset: both domains of unit 0 only
        wr(`SRC_OFS_PRST0, 32'h0000_0001);
        @(posedge clk);
        chk({prst_n[32], prst_n[1], prst_n[0]}, 3'b010);
        wr(`SRC_OFS_PRST0, 32'h0000_0000);
        @(posedge clk);
        chk({prst_n[32], prst_n[0]}, 2'b11);
        // software system request
        wr(`SRC_OFS_SYS_CTRL, 32'h0000_0001);
        wait_sys(0);
        wait_sys(1);
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0017);
        // watchdog: first zero interrupts, second zero resets
        wr(`SRC_OFS_WD_LOAD, 32'd30);
        wr(`SRC_OFS_WD_CTRL, 32'h0000_0003);
        for (n = 0; n < 200 && wdt_irq !== 1'b1; n++) @(posedge clk);
        chk({wdt_irq, sys_n}, 2'b11);
        repeat (20) @(posedge clk);
        chk(sys_n, 1'b1);
        wait_sys(0);
        wait_sys(1);
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_001F);
        wr(`SRC_OFS_CAUSE, 32'h0000_0000);
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0000);
        // second power-on leaves only its own indicator
        @(posedge clk);
        rst_n <= 0;
        @(posedge clk);
        @(negedge clk);
        chk(tap_n, 1'b0);
        por();
        rdr(`SRC_OFS_CAUSE);
        chk(rd, 32'h0000_0002);
        finish_test();
    end
endmodule
